// >>> shared/psr_pkg.sv
package psr_pkg;
   // Management frame field widths and codes
   localparam int             ADDR_W        = 5;
   localparam int             DATA_W        = 16;
   localparam int             CNT_W         = 6;
   localparam logic [1:0]     OP_READ       = 2'h2;
   localparam logic [1:0]     OP_WRITE      = 2'h1;
   localparam logic [1:0]     TA_WRITE      = 2'h2;
   localparam logic [5:0]     PREAMBLE_BITS = 6'h20;
   localparam logic [5:0]     LAST_ADDR_BIT = 6'h04;
   localparam logic [5:0]     LAST_DATA_BIT = 6'h0F;

   // Register addresses on the management interface
   localparam logic [4:0]     REG_STATUS    = 5'h01;
   localparam logic [4:0]     REG_ID_HIGH   = 5'h02;
   localparam logic [4:0]     REG_ID_LOW    = 5'h03;

   // Status word: permanent ones at 14:11, 6, 3 and 0; bits 15 and 10:7 read zero
   localparam logic [15:0]    STATUS_FIXED  = 16'h7849;
   localparam logic [15:0]    STATUS_RSVD   = 16'h0780;
   localparam int             BIT_AN_DONE   = 5;
   localparam int             BIT_RFAULT    = 4;
   localparam int             BIT_LINK      = 2;
   localparam int             BIT_JABBER    = 1;

   // Identifier layout in the second identifier word
   localparam int             ID_OUI_POS    = 10;
   localparam int             ID_MODEL_POS  = 4;

   // Arbitrary neutral identity values, not any real maker's codes
   localparam logic [21:0]    OUI_DEFAULT   = 22'h012345;
   localparam logic [5:0]     MODEL_DEFAULT = 6'h01;
   localparam logic [3:0]     REV_DEFAULT   = 4'h0;

   typedef enum logic [2:0] {
      S_HUNT  = 3'b000,
      S_START = 3'b001,
      S_OP    = 3'b010,
      S_PHY   = 3'b011,
      S_REG   = 3'b100,
      S_TA    = 3'b101,
      S_RDATA = 3'b110,
      S_WDATA = 3'b111
   } psr_state_t;
endpackage

// >>> src/psr_status_regs.sv
`timescale 1ns/10ps
module psr_status_regs #(
   parameter logic [4:0]  PHY_ADDR  = 5'h01,
   parameter bit          ID_ENABLE = 1'b1,
   parameter logic [21:0] OUI_BITS  = psr_pkg::OUI_DEFAULT,
   parameter logic [5:0]  MODEL     = psr_pkg::MODEL_DEFAULT,
   parameter logic [3:0]  REVISION  = psr_pkg::REV_DEFAULT
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic mdc,
   input  wire logic mdioIn,
   output logic      mdioOut,
   output logic      mdioOe_n,
   input  wire logic anComplete,
   input  wire logic linkGood,
   input  wire logic remoteFaultEvent,
   input  wire logic jabberEvent
);
   import psr_pkg::*;

   logic              mdcSync1;
   logic              mdcSync2;
   logic              mdcPrev;
   logic              mdioSync1;
   logic              mdioSync2;
   logic              mdcRise;
   logic              bitIn;

   psr_state_t        state;
   psr_state_t        next_state;
   logic [CNT_W-1:0]  bitCnt;
   logic [CNT_W-1:0]  next_bitCnt;
   logic              preambleSeen;
   logic              next_preambleSeen;
   logic [1:0]        opcode;
   logic [1:0]        next_opcode;
   logic [ADDR_W-1:0] phyShift;
   logic [ADDR_W-1:0] next_phyShift;
   logic [ADDR_W-1:0] regShift;
   logic [ADDR_W-1:0] next_regShift;
   logic              selected;
   logic              next_selected;
   logic              taFirst;
   logic              next_taFirst;
   logic [DATA_W-1:0] readShift;
   logic [DATA_W-1:0] next_readShift;
   logic              next_mdioOut;
   logic              next_mdioOe_n;

   logic              rfLatch;
   logic              next_rfLatch;
   logic              jabLatch;
   logic              next_jabLatch;
   logic              linkLatch;
   logic              next_linkLatch;
   logic              anDone;
   logic              next_anDone;
   logic              statusRead;
   logic [DATA_W-1:0] statusWord;
   logic [DATA_W-1:0] idHigh;
   logic [DATA_W-1:0] idLow;
   logic [DATA_W-1:0] readValue;
   logic [ADDR_W-1:0] regFull;

   // Preamble counter must be able to hold the full 32 ones; refused at elaboration
   if (CNT_W < 6) begin : g_cnt_check
      $error("psr_status_regs: bit counter too narrow for preamble");
   end

   // Both pins are asynchronous to sys_clk, so two flops before any logic
   // Clock chain resets high so an idle-high clock shows no false rise after reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mdcSync1  <= 1'b1;
         mdcSync2  <= 1'b1;
         mdcPrev   <= 1'b1;
         mdioSync1 <= 1'b1;
         mdioSync2 <= 1'b1;
      end else begin
         mdcSync1  <= mdc;
         mdcSync2  <= mdcSync1;
         mdcPrev   <= mdcSync2;
         mdioSync1 <= mdioIn;
         mdioSync2 <= mdioSync1;
      end
   end

   assign mdcRise = mdcSync2 & ~mdcPrev;
   assign bitIn   = mdioSync2;
   assign regFull = {regShift[ADDR_W-2:0], bitIn};

   // Read words; reserved bits masked off, permanent bits forced
   always_comb begin
      statusWord             = STATUS_FIXED & ~STATUS_RSVD;
      statusWord[BIT_AN_DONE] = anDone;
      statusWord[BIT_RFAULT]  = rfLatch;
      statusWord[BIT_LINK]    = linkLatch;
      statusWord[BIT_JABBER]  = jabLatch;
      if (ID_ENABLE) begin
         idHigh = OUI_BITS[21:6];
         idLow  = {OUI_BITS[5:0], MODEL, REVISION};
      end else begin
         idHigh = 16'h0000;
         idLow  = 16'h0000;
      end
      case (regFull)
         REG_STATUS:  readValue = statusWord;
         REG_ID_HIGH: readValue = idHigh;
         REG_ID_LOW:  readValue = idLow;
         default:     readValue = 16'h0000;
      endcase
   end

   // Status read is recognised on the edge that ends the register address
   assign statusRead = mdcRise && (state == S_REG) && (bitCnt == LAST_ADDR_BIT)
                       && (opcode == OP_READ) && (phyShift == PHY_ADDR)
                       && (regFull == REG_STATUS);

   // Frame decoder, advanced only on rising edges of the management clock
   always_comb begin
      next_state        = state;
      next_bitCnt       = bitCnt;
      next_preambleSeen = preambleSeen;
      next_opcode       = opcode;
      next_phyShift     = phyShift;
      next_regShift     = regShift;
      next_selected     = selected;
      next_taFirst      = taFirst;
      next_readShift    = readShift;
      next_mdioOut      = mdioOut;
      next_mdioOe_n     = mdioOe_n;
      if (mdcRise) begin
         case (state)
            S_HUNT: begin
               if (bitIn) begin
                  if (bitCnt != PREAMBLE_BITS) begin
                     next_bitCnt = bitCnt + 6'h01;
                  end
               end else if (preambleSeen || bitCnt == PREAMBLE_BITS) begin
                  next_preambleSeen = 1'b1;
                  next_state        = S_START;
                  next_bitCnt       = 6'h00;
               end else begin
                  next_bitCnt = 6'h00;
               end
            end
            S_START: begin
               next_state = bitIn ? S_OP : S_HUNT;
            end
            S_OP: begin
               next_opcode = {opcode[0], bitIn};
               if (bitCnt == 6'h01) begin
                  next_bitCnt = 6'h00;
                  if ({opcode[0], bitIn} == OP_READ || {opcode[0], bitIn} == OP_WRITE) begin
                     next_state = S_PHY;
                  end else begin
                     next_preambleSeen = 1'b0;
                     next_state        = S_HUNT;
                  end
               end else begin
                  next_bitCnt = bitCnt + 6'h01;
               end
            end
            S_PHY: begin
               next_phyShift = {phyShift[ADDR_W-2:0], bitIn};
               next_bitCnt   = (bitCnt == LAST_ADDR_BIT) ? 6'h00 : bitCnt + 6'h01;
               if (bitCnt == LAST_ADDR_BIT) begin
                  next_state = S_REG;
               end
            end
            S_REG: begin
               next_regShift = regFull;
               next_bitCnt   = (bitCnt == LAST_ADDR_BIT) ? 6'h00 : bitCnt + 6'h01;
               if (bitCnt == LAST_ADDR_BIT) begin
                  next_state     = S_TA;
                  next_selected  = (phyShift == PHY_ADDR);
                  next_readShift = readValue;
               end
            end
            S_TA: begin
               next_taFirst = bitIn;
               if (bitCnt == 6'h00) begin
                  next_bitCnt = 6'h01;
                  if (selected && opcode == OP_READ) begin
                     next_mdioOut  = 1'b0;                  // Second turnaround bit
                     next_mdioOe_n = 1'b0;
                  end
               end else begin
                  next_bitCnt = 6'h00;
                  if (opcode == OP_READ) begin
                     next_state     = S_RDATA;
                     next_mdioOut   = readShift[DATA_W-1];
                     next_readShift = {readShift[DATA_W-2:0], 1'b0};
                  end else if ({taFirst, bitIn} == TA_WRITE) begin
                     next_state = S_WDATA;
                  end else begin
                     next_preambleSeen = 1'b0;
                     next_state        = S_HUNT;
                  end
               end
            end
            S_RDATA: begin
               // Drive changes right after the edge the station samples on
               next_mdioOut   = readShift[DATA_W-1];
               next_readShift = {readShift[DATA_W-2:0], 1'b0};
               next_bitCnt    = bitCnt + 6'h01;
               if (bitCnt == LAST_DATA_BIT) begin
                  next_mdioOut  = 1'b1;
                  next_mdioOe_n = 1'b1;
                  next_state    = S_HUNT;
                  next_bitCnt   = 6'h00;
               end
            end
            S_WDATA: begin
               // Every addressed word here is read-only; data is dropped
               next_bitCnt = bitCnt + 6'h01;
               if (bitCnt == LAST_DATA_BIT) begin
                  next_state  = S_HUNT;
                  next_bitCnt = 6'h00;
               end
            end
            default: begin
               next_state  = S_HUNT;
               next_bitCnt = 6'h00;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state        <= S_HUNT;
         bitCnt       <= 6'h00;
         preambleSeen <= 1'b0;
         opcode       <= 2'h0;
         phyShift     <= 5'h00;
         regShift     <= 5'h00;
         selected     <= 1'b0;
         taFirst      <= 1'b0;
         readShift    <= 16'h0000;
         mdioOut      <= 1'b1;
         mdioOe_n     <= 1'b1;
      end else begin
         state        <= next_state;
         bitCnt       <= next_bitCnt;
         preambleSeen <= next_preambleSeen;
         opcode       <= next_opcode;
         phyShift     <= next_phyShift;
         regShift     <= next_regShift;
         selected     <= next_selected;
         taFirst      <= next_taFirst;
         readShift    <= next_readShift;
         mdioOut      <= next_mdioOut;
         mdioOe_n     <= next_mdioOe_n;
      end
   end

   // Latched status; a new event in the read cycle survives the clear
   always_comb begin
      next_anDone   = anComplete;
      next_rfLatch  = remoteFaultEvent | (rfLatch & ~statusRead);
      next_jabLatch = jabberEvent | (jabLatch & ~statusRead);
      // Failure drops the bit at once; only a read lets good link back in
      next_linkLatch = statusRead ? linkGood : (linkLatch & linkGood);
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         anDone    <= 1'b0;
         rfLatch   <= 1'b0;
         jabLatch  <= 1'b0;
         linkLatch <= 1'b0;
      end else begin
         anDone    <= next_anDone;
         rfLatch   <= next_rfLatch;
         jabLatch  <= next_jabLatch;
         linkLatch <= next_linkLatch;
      end
   end
endmodule

// >>> verification/psr_status_monitor.sv
`timescale 1ns/10ps
module psr_status_monitor #(
   parameter bit          ID_ENABLE = 1'b1,
   parameter logic [21:0] OUI_BITS = psr_pkg::OUI_DEFAULT,
   parameter logic [5:0]  MODEL    = psr_pkg::MODEL_DEFAULT,
   parameter logic [3:0]  REVISION = psr_pkg::REV_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic mdc,
   input wire logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe_n,
   input wire logic anComplete,
   input wire logic linkGood,
   input wire logic remoteFaultEvent,
   input wire logic jabberEvent
);
   import psr_pkg::*;
   logic        mdcQ, oeQ, rfM, jbM, lkM;
   logic [31:0] h;
   logic        endRead, stat;
   // A read ends when the device lets go; the history then holds the whole frame
   assign endRead = mdioOe_n && !oeQ;
   assign stat    = endRead && h[22:18] == REG_STATUS;
   // Wire history and reference latches; only valid while events stay out of frames
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {mdcQ, oeQ, rfM, jbM, lkM} <= 5'h08;
         h <= 32'h0;
      end else begin
         mdcQ <= mdc;
         oeQ  <= mdioOe_n;
         if (mdc && !mdcQ) h <= {h[30:0], mdioIn};
         rfM  <= stat ? remoteFaultEvent : rfM | remoteFaultEvent;
         jbM  <= stat ? jabberEvent : jbM | jabberEvent;
         lkM  <= stat ? linkGood : lkM & linkGood;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_reserved_zero: assert property (stat |-> (h[15:0] & STATUS_RSVD) == 16'h0000)
      else $error("reserved status bits read nonzero");
   a_fixed_ones: assert property (stat |-> (h[15:0] & STATUS_FIXED) == STATUS_FIXED)
      else $error("permanent status ones missing");
   a_an_done: assert property (stat |-> h[5] == $past(anComplete, 2))
      else $error("negotiation done bit wrong");
   a_fault_latch: assert property ($rose(mdioOe_n) && h[22:18] == REG_STATUS |-> h[4] == rfM)
      else $error("remote fault latch wrong");
   a_link_latch: assert property (stat |-> h[2] == lkM)
      else $error("link latch wrong");
   a_jabber_latch: assert property (stat |-> h[1] == jbM)
      else $error("jabber latch wrong");
   a_id_high: assert property (endRead && h[22:18] == REG_ID_HIGH |->
      h[15:0] == (ID_ENABLE ? OUI_BITS[21:6] : 16'h0000))
      else $error("identifier word one wrong");
   a_id_low: assert property (endRead && h[22:18] == REG_ID_LOW |->
      h[15:0] == (ID_ENABLE ? {OUI_BITS[5:0], MODEL, REVISION} : 16'h0000))
      else $error("identifier word two wrong");
endmodule
bind psr_status_regs psr_status_monitor #(.ID_ENABLE(ID_ENABLE), .OUI_BITS(OUI_BITS),
   .MODEL(MODEL), .REVISION(REVISION))
   u_psr_status_monitor (.sys_clk(sys_clk), .reset_n(reset_n), .mdc(mdc), .mdioIn(mdioIn),
   .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .anComplete(anComplete), .linkGood(linkGood),
   .remoteFaultEvent(remoteFaultEvent), .jabberEvent(jabberEvent));

// >>> verification/psr_station_model.sv
`timescale 1ns/10ps
module psr_station_model (
   input  wire logic sys_clk,
   input  wire logic mdioWire,
   output logic      mdc,
   output logic      stBit,
   output logic      stOe_n
);
   import psr_pkg::*;
   int lowLen = 4;
   initial {mdc, stBit, stOe_n} = 3'h3;
   // Data changes while the clock is low, sampled at the rise; clock idles when no frame
   task automatic bitCycle(input logic drive, input logic b, output logic seen);
      @(posedge sys_clk) #1;
      mdc    = 1'h0;
      stOe_n = !drive;
      stBit  = b;
      repeat (lowLen) @(posedge sys_clk);
      #1 mdc = 1'h1;
      seen = mdioWire;
      repeat (3) @(posedge sys_clk);
   endtask
   // Whole frame; the line is let go for turnaround and data of a read
   task automatic xfer(input bit pre, input logic [1:0] op, input logic [4:0] phy, rg,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] fr;
      logic        s;
      fr = {2'h1, op, phy, rg, TA_WRITE, wd};
      if (pre) repeat (32) bitCycle(1'h1, 1'h1, s);
      for (int i = 31; i >= 0; i--) begin
         bitCycle(op != OP_READ || i > 17, fr[i], s);
         if (i < 16) rd[i] = s;
      end
      @(posedge sys_clk) #1 stOe_n = 1'h1;
   endtask
endmodule

// >>> verification/tb_psr_status_regs.sv
`timescale 1ns/10ps
module tb_psr_status_regs;
   import psr_pkg::*;
   logic        sys_clk = 1'h0, reset_n = 1'h0, anComplete = 1'h0, linkGood = 1'h0;
   logic        remoteFaultEvent = 1'h0, jabberEvent = 1'h0, rfM = 1'h0, jbM = 1'h0, lkM = 1'h0;
   logic        mdc, stBit, stOe_n, mdioOut, mdioOe_n, mdioIn;
   logic [15:0] rd;
   int          badCount = 0, checks = 0, seed = 94233;
   always #10 sys_clk = ~sys_clk;
   // Pulled-up wire: released by both sides reads one
   assign mdioIn = !mdioOe_n ? mdioOut : (!stOe_n ? stBit : 1'h1);
   psr_status_regs u_psr_status_regs (.sys_clk(sys_clk), .reset_n(reset_n), .mdc(mdc),
      .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .anComplete(anComplete),
      .linkGood(linkGood), .remoteFaultEvent(remoteFaultEvent), .jabberEvent(jabberEvent));
   psr_station_model u_psr_station_model (.sys_clk(sys_clk), .mdioWire(mdioIn), .mdc(mdc),
      .stBit(stBit), .stOe_n(stOe_n));
   task automatic check(input logic [15:0] got, exp);
      checks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (badCount == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rdReg(input bit pre, input logic [4:0] phy, rg);
      u_psr_station_model.xfer(pre, OP_READ, phy, rg, 16'h0000, rd);
   endtask
   // Expectation is fixed before the read, which then clears and re-arms the latches
   task automatic rdStat(input bit pre);
      logic [15:0] e;
      e = STATUS_FIXED | {10'h000, anComplete, rfM, 1'h0, lkM, jbM, 1'h0};
      rdReg(pre, 5'h01, REG_STATUS);
      check(rd, e);
      {rfM, jbM, lkM} = {2'h0, linkGood};
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      #1 reset_n = 1'h1;
      repeat (3) @(posedge sys_clk);
      #1 linkGood = 1'h1;
      rdReg(0, 5'h01, REG_STATUS);
      check(rd, 16'hFFFF);
      rdStat(1);
      rdStat(0);
      // Writes to registers 1 to 3, then identifier words must be untouched
      for (int r = 1; r < 4; r++) u_psr_station_model.xfer(0, OP_WRITE, 5'h01, r[4:0], 16'(~r), rd);
      rdStat(0);
      rdReg(0, 5'h01, REG_ID_HIGH);
      check(rd, OUI_DEFAULT[21:6]);
      rdReg(0, 5'h01, REG_ID_LOW);
      check(rd, {OUI_DEFAULT[5:0], MODEL_DEFAULT, REV_DEFAULT});
      rdReg(0, 5'h01, 5'h1F);
      check(rd, 16'h0000);
      rdReg(0, 5'h1E, REG_STATUS);
      check(rd, 16'hFFFF);
      // Both illegal opcodes force a fresh preamble
      for (int k = 0; k < 2; k++) begin
         u_psr_station_model.xfer(0, k ? 2'h3 : 2'h0, 5'h01, REG_STATUS, 16'h0000, rd);
         rdReg(0, 5'h01, REG_STATUS);
         check(rd, 16'hFFFF);
         rdStat(1);
      end
      repeat (40) begin
         u_psr_station_model.lowLen = 3 + ($unsigned($random(seed)) % 4);
         @(posedge sys_clk) #1 anComplete = 1'($random(seed));
         linkGood = 1'($random(seed) % 3 != 0);
         lkM &= linkGood;
         @(posedge sys_clk) #1 {remoteFaultEvent, jabberEvent} = 2'($random(seed));
         {rfM, jbM} |= {remoteFaultEvent, jabberEvent};
         linkGood = 1'($random(seed) % 4 != 0);
         lkM &= linkGood;
         @(posedge sys_clk) #1 {remoteFaultEvent, jabberEvent} = 2'h0;
         rdStat(1'($random(seed)));
      end
      // Latch both events, then a mid-run reset must clear them and ask for a new preamble
      @(posedge sys_clk) #1 {remoteFaultEvent, jabberEvent} = 2'h3;
      @(posedge sys_clk) #1 {remoteFaultEvent, jabberEvent} = 2'h0;
      reset_n = 1'h0;
      repeat (3) @(posedge sys_clk);
      #1 reset_n = 1'h1;
      {rfM, jbM, lkM} = 3'h0;
      rdReg(0, 5'h01, REG_STATUS);
      check(rd, 16'hFFFF);
      rdStat(1);
      stop_test();
   end
   // Bounded run: far more than the frames above need
   initial begin
      repeat (90000) @(posedge sys_clk);
      badCount++;
      stop_test();
   end
endmodule
